// ===== design/sleep_wake_consts.vh
// Constants for the sleep, wake-up and watchdog control block
`ifndef SLEEP_WAKE_CONSTS_VH
`define SLEEP_WAKE_CONSTS_VH
// Wishbone register byte addresses
`define REG_CTRL_ADDR 8'h00
`define REG_STAT_ADDR 8'h04
`define REG_CAUSE_ADDR 8'h08
`define REG_TABLE_ADDR 8'h0c
`define REG_TDATA_ADDR 8'h10
// Control register fields (sleep, kick and table bits pulse on a one; interrupt disable, receive enable and mask are stored)
`define CTRL_SLEEP_BIT 0
`define CTRL_KICK_BIT 1
`define CTRL_GLOBAL_INT_DISABLE_BIT 2
`define CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT 3
`define CTRL_TABRD_BIT 4
`define CTRL_TABWR_BIT 5
`define CTRL_MASK_LSB 8
// Status bits of the cpu status register
`define STAT_PD_BIT 2
`define STAT_TO_BIT 3
// Fuse map
`define FUSE_BASE 16'hfe00
`define FUSE_ERASED 8'hff
`define FUSE_OSC0 0
`define FUSE_OSC_IN_PIN 1
`define FUSE_DOG0 2
`define FUSE_DOG1 3
`define FUSE_MEM0 4
`define FUSE_MEM1 6
`define USER_LIMIT 16'h0800
`define CRYPT_KEY 16'ha5c3
// Oscillator modes {fuse1,fuse0}
`define OSC_LF 2'h0
`define OSC_RC 2'h1
`define OSC_XT 2'h2
`define OSC_EC 2'h3
// Memory modes {fuse1,fuse0}
`define MEM_PROT 2'h0
`define MEM_EXT 2'h1
`define MEM_MCU 2'h2
`define MEM_MPU 2'h3
// Watchdog modes {fuse1,fuse0}
`define DOG_TIMER 2'h0
`define DOG_P64 2'h1
`define DOG_P256 2'h2
`define DOG_P1 2'h3
// Timing
`define OST_PERIODS 11'h400
`define CLK_HZ 50000000
`define CORE_DIV 8'h03
`endif

// ===== design/dog_counter.v
// Watchdog: 8-bit prescaler feeding an 8-bit counter
`timescale 1ns/1ps
`include "sleep_wake_consts.vh"
module dog_counter (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Control
  input wire clear,
  input wire tick,
  input wire [1:0] mode,
  // Result
  output reg overflow
);
  reg [7:0] preR;
  reg [7:0] cntR;
  reg [7:0] limit;
  always @* begin
    case (mode)
      `DOG_P64: limit = 8'h3f;
      `DOG_P1: limit = 8'h00;
      default: limit = 8'hff;
    endcase
  end
  // =========================================
  // Counting
  always @(posedge clock) begin
    if (sys_rst || clear) begin
      preR <= 8'h00;
      cntR <= 8'h00;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (tick) begin
        if (preR >= limit) begin
          preR <= 8'h00;
          cntR <= cntR + 8'h01;
          if (cntR == 8'hff)
            overflow <= 1'b1;
        end else begin
          preR <= preR + 8'h01;
        end
      end
    end
  end
endmodule // dog_counter

// ===== design/osc_startup.v
// Oscillator start-up hold counter
`timescale 1ns/1ps
`include "sleep_wake_consts.vh"
module osc_startup (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Control
  input wire start,
  input wire oscEdge,
  // Status
  output reg busy
);
  reg [10:0] cntR;
  always @(posedge clock) begin
    if (sys_rst) begin
      cntR <= 11'h000;
      busy <= 1'b0;
    end else if (start) begin
      cntR <= 11'h000;
      busy <= 1'b1;
    end else if (busy && oscEdge) begin
      cntR <= cntR + 11'h001;
      if (cntR == `OST_PERIODS - 11'h001)
        busy <= 1'b0;
    end
  end
endmodule // osc_startup

// ===== design/sleep_wake_watchdog_control.v
// Sleep, wake-up, watchdog, code protection and fuse control
// =========================================
// Overview of operation
// - Sleep stops oscillator, sets timeout, clears powerdown
// - Powered down: crystal pins float, else out low
// - No internal clock while powered down
// - Timer pin edges advance prescaler, not counter
// - Interrupt wakes only if masked-in at entry
// - Global disable chooses vector or continue
// - Wake only on reset, clear, watchdog, interrupt
// - Capture prescaler runs; capture after wake
// - Serial transfer end during sleep wakes device
// - Slave receive shifter keeps shifting while asleep
// - Crystal modes hold reset 1024 periods on wake
// - Interrupt at sleep fetch makes sleep a nop
// - Reset kinds load zero, flags per kind
// - After wake run next instruction, then branch
// - Watchdog is hidden 8-bit counter, 8-bit prescaler
// - Dog fuses choose clock and prescale
// - Kick, sleep, power-on clear dog, set timeout
// - Dog overflow resets chip when enabled
// - Plain timer: clears timeout, no reset, stops asleep
// - Protected table access from test memory restricted
// - Fuse read in protected or MCU mode returns fuses low, ones high
// - Table write to fuse programs it to zero
`timescale 1ns/1ps
`include "sleep_wake_consts.vh"
module sleep_wake_watchdog_control (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Asynchronous pins
  input wire masterClearPinN,
  input wire oscInPin,
  input wire dogRcClk,
  input wire timerClockPin,
  input wire intPin,
  input wire captureOnePin,
  input wire captureTwoEvt,
  input wire portBChange,
  input wire serialClkPin,
  input wire serialDataPin,
  // Core side events
  input wire sleepFetchIrq,
  input wire timerEdgeSelect,
  input wire timerExtClk,
  input wire serialTxBusy,
  // Oscillator pin control
  output reg oscInOe,
  output reg oscOutOut,
  output reg oscOutOe,
  // Core control
  output reg coreClkEn,
  output reg coreReset,
  output reg vectorReq,
  output reg resumeNext,
  output reg [7:0] timerPrescale,
  output reg [7:0] serialShift,
  output reg captureReq
);
  // =========================================
  // Pin synchronisers
  reg [9:0] syncA_r;
  reg [9:0] syncB_r;
  wire mclrN = syncB_r[0];
  wire oscS = syncB_r[1];
  wire rcS = syncB_r[2];
  wire tckS = syncB_r[3];
  wire intS = syncB_r[4];
  wire cap1S = syncB_r[5];
  wire cap2S = syncB_r[6];
  wire pbS = syncB_r[7];
  wire sckS = syncB_r[8];
  wire sdS = syncB_r[9];
  reg [9:0] last_r;
  wire [9:0] rise = syncB_r & ~last_r;
  wire [9:0] fall = ~syncB_r & last_r;
  always @(posedge clock) begin
    if (sys_rst) begin
      syncA_r <= 10'h001;
      syncB_r <= 10'h001;
      last_r <= 10'h001;
    end else begin
      syncA_r <= {serialDataPin, serialClkPin, portBChange, captureTwoEvt, captureOnePin,
                  intPin, timerClockPin, dogRcClk, oscInPin, masterClearPinN};
      syncB_r <= syncA_r;
      last_r <= syncB_r;
    end
  end
  // =========================================
  // Fuses and state
  reg [7:0] fuse_r;
  reg asleep_r;
  reg to_r;
  reg pd_r;
  reg global_int_disable_r;
  reg continuous_receive_enable_r;
  reg [5:0] mask_r;
  reg [5:0] maskAtSleep_r;
  reg [15:0] tabAddr_r;
  reg [15:0] tabPc_r;
  reg [15:0] tabData_r;
  reg [15:0] tabLatch_r;
  reg [7:0] coreDiv_r;
  reg [2:0] cause_r;
  reg needIrqTerm_r;
  reg [2:0] state_r;
  localparam ST_RUN = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_HOLD = 3'h4;
  wire [1:0] oscMode = {fuse_r[`FUSE_OSC_IN_PIN], fuse_r[`FUSE_OSC0]};
  wire [1:0] dogMode = {fuse_r[`FUSE_DOG1], fuse_r[`FUSE_DOG0]};
  wire [1:0] memMode = {fuse_r[`FUSE_MEM1], fuse_r[`FUSE_MEM0]};
  wire crystal = (oscMode == `OSC_XT) || (oscMode == `OSC_LF);
  wire plainTimer = (dogMode == `DOG_TIMER);

  // True when a table address falls in the fuse block
  function isFuse;
    input [15:0] a;
    begin
      isFuse = (a[15:3] == `FUSE_BASE >> 3);
    end
  endfunction

  // =========================================
  // Wishbone decode
  wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wbWr = wbReq && wb_we_i;
  wire ctrlWr = wbWr && (wb_adr_i == `REG_CTRL_ADDR) && wb_sel_i[0];
  wire sleepCmd = ctrlWr && wb_dat_i[`CTRL_SLEEP_BIT] && state_r == ST_RUN;
  wire kickCmd = ctrlWr && wb_dat_i[`CTRL_KICK_BIT];
  wire tabRdCmd = ctrlWr && wb_dat_i[`CTRL_TABRD_BIT];
  wire tabWrCmd = ctrlWr && wb_dat_i[`CTRL_TABWR_BIT];

  // =========================================
  // Watchdog
  wire dogTick = plainTimer ? (state_r == ST_RUN && coreDiv_r == 8'h00) : rise[2];
  wire dogOvf;
  reg dogClr;
  always @* begin
    dogClr = kickCmd || (sleepCmd && !sleepFetchIrq) || !mclrN;
  end
  dog_counter dogUnit (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(dogClr),
    .tick(dogTick && (state_r != ST_SLEEP || !plainTimer)),
    .mode(dogMode),
    .overflow(dogOvf)
  );

  // =========================================
  // Start-up hold
  reg ostStart;
  wire ostBusy;
  osc_startup ostUnit (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(ostStart),
    .oscEdge(rise[1]),
    .busy(ostBusy)
  );

  // Wake sources: timer pin, int pin, cap1, cap2, port B, serial
  reg txWas_r;
  reg rxDone_r;
  reg [2:0] bitCnt_r;
  // Capture waits until the core runs again, so the captured time is stale
  reg capWake_r;
  reg [5:0] irqEvt;
  always @* begin
    irqEvt = {1'b0, pbS & rise[7], rise[6], rise[5], rise[4],
              timerEdgeSelect ? rise[3] : fall[3]};
    irqEvt[5] = (!serialTxBusy && state_r == ST_SLEEP && txWas_r) ||
                (continuous_receive_enable_r && rxDone_r);
  end
  wire wakeIrq = |(irqEvt & maskAtSleep_r);

  // =========================================
  // Main sequencing
  always @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_RUN;
      to_r <= 1'b1;
      pd_r <= 1'b1;
      asleep_r <= 1'b0;
      global_int_disable_r <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      mask_r <= 6'h00;
      maskAtSleep_r <= 6'h00;
      fuse_r <= `FUSE_ERASED;
      tabAddr_r <= 16'h0000;
      tabPc_r <= 16'h0000;
      tabData_r <= 16'h0000;
      tabLatch_r <= 16'h0000;
      coreDiv_r <= 8'h00;
      cause_r <= 3'h0;
      needIrqTerm_r <= 1'b0;
      coreReset <= 1'b1;
      coreClkEn <= 1'b0;
      vectorReq <= 1'b0;
      resumeNext <= 1'b0;
      ostStart <= 1'b0;
      timerPrescale <= 8'h00;
      serialShift <= 8'h00;
      captureReq <= 1'b0;
      txWas_r <= 1'b0;
      rxDone_r <= 1'b0;
      bitCnt_r <= 3'h0;
      capWake_r <= 1'b0;
      oscInOe <= 1'b0;
      oscOutOut <= 1'b0;
      oscOutOe <= 1'b0;
    end else begin
      ostStart <= 1'b0;
      vectorReq <= 1'b0;
      resumeNext <= 1'b0;
      captureReq <= 1'b0;
      rxDone_r <= 1'b0;
      coreDiv_r <= (coreDiv_r == `CORE_DIV) ? 8'h00 : coreDiv_r + 8'h01;
      if (timerExtClk && (timerEdgeSelect ? rise[3] : fall[3]))
        timerPrescale <= timerPrescale + 8'h01;
      if (sckS == 1'b0 && last_r[8] == 1'b1) begin
        serialShift <= {serialShift[6:0], sdS};
        bitCnt_r <= bitCnt_r + 3'h1;
        if (bitCnt_r == 3'h7)
          rxDone_r <= 1'b1;
      end
      if (ctrlWr) begin
        global_int_disable_r <= wb_dat_i[`CTRL_GLOBAL_INT_DISABLE_BIT];
        continuous_receive_enable_r <= wb_dat_i[`CTRL_CONTINUOUS_RECEIVE_ENABLE_BIT];
        mask_r <= wb_dat_i[`CTRL_MASK_LSB+5:`CTRL_MASK_LSB];
      end
      if (wbWr && wb_adr_i == `REG_TABLE_ADDR) begin
        tabAddr_r <= wb_dat_i[15:0];
        tabPc_r <= wb_dat_i[31:16];
      end
      if (wbWr && wb_adr_i == `REG_TDATA_ADDR)
        tabData_r <= wb_dat_i[15:0];
      if (kickCmd)
        to_r <= 1'b1;
      if (tabRdCmd) begin
        if (isFuse(tabAddr_r) && (memMode == `MEM_PROT || memMode == `MEM_MCU))
          tabLatch_r <= {8'hff, fuse_r};
        else if (memMode == `MEM_PROT && tabPc_r >= `USER_LIMIT)
          tabLatch_r <= tabAddr_r ^ `CRYPT_KEY;
        else
          tabLatch_r <= tabAddr_r;
      end
      if (tabWrCmd) begin
        tabLatch_r <= tabData_r;
        needIrqTerm_r <= (memMode == `MEM_PROT && tabPc_r >= `USER_LIMIT);
        if (isFuse(tabAddr_r) && !(memMode == `MEM_PROT && tabPc_r >= `USER_LIMIT))
          fuse_r[tabAddr_r[2:0]] <= 1'b0;
      end
      if (wakeIrq)
        needIrqTerm_r <= 1'b0;
      case (state_r)
        ST_RUN: begin
          coreClkEn <= 1'b1;
          coreReset <= !mclrN;
          if (!mclrN) begin
            state_r <= ST_HOLD;
            cause_r <= 3'h1;
          end else if (dogOvf) begin
            to_r <= 1'b0;
            if (!plainTimer) begin
              coreReset <= 1'b1;
              state_r <= ST_HOLD;
              cause_r <= 3'h2;
            end
          end else if (sleepCmd && !sleepFetchIrq) begin
            state_r <= ST_SLEEP;
            asleep_r <= 1'b1;
            to_r <= 1'b1;
            pd_r <= 1'b0;
            coreClkEn <= 1'b0;
            maskAtSleep_r <= mask_r;
            txWas_r <= serialTxBusy;
            oscInOe <= 1'b0;
            oscOutOut <= 1'b0;
            oscOutOe <= !crystal;
          end
        end
        ST_SLEEP: begin
          coreClkEn <= 1'b0;
          if (!mclrN || dogOvf || wakeIrq) begin
            asleep_r <= 1'b0;
            oscOutOe <= 1'b0;
            ostStart <= crystal;
            coreReset <= crystal || !mclrN || dogOvf;
            state_r <= ST_HOLD;
            if (dogOvf)
              to_r <= 1'b0;
            cause_r <= !mclrN ? 3'h1 : (dogOvf ? 3'h2 : 3'h4);
            capWake_r <= irqEvt[2] && maskAtSleep_r[2];
          end
        end
        ST_HOLD: begin
          if (!ostStart && !ostBusy && mclrN) begin
            state_r <= ST_RUN;
            coreReset <= 1'b0;
            coreClkEn <= 1'b1;
            captureReq <= capWake_r;
            capWake_r <= 1'b0;
            if (cause_r == 3'h4) begin
              vectorReq <= !global_int_disable_r;
              resumeNext <= global_int_disable_r;
            end
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // =========================================
  // Register read and ack, one wait-free cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL_ADDR: wb_dat_o <= {18'h00000, mask_r, 4'h0, continuous_receive_enable_r, global_int_disable_r, 2'h0};
          `REG_STAT_ADDR: wb_dat_o <= {20'h00000, fuse_r, to_r, pd_r, asleep_r, 1'b0};
          `REG_CAUSE_ADDR: wb_dat_o <= {28'h0000000, needIrqTerm_r, cause_r};
          `REG_TABLE_ADDR: wb_dat_o <= {tabPc_r, tabAddr_r};
          `REG_TDATA_ADDR: wb_dat_o <= {16'h0000, tabLatch_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sleep_wake_watchdog_control

// ===== testbench/sleep_wake_sva.sv
// Port assertions for the sleep, wake-up and watchdog control block
`timescale 1ns/1ps
module sleep_wake_sva (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Pins and core control
  input wire masterClearPinN,
  input wire oscInOe,
  input wire oscOutOut,
  input wire oscOutOe,
  input wire coreClkEn,
  input wire coreReset,
  input wire vectorReq,
  input wire resumeNext,
  input wire captureReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Settled sleep: a wake in progress may still hold the pins for a cycle
  sequence asleep3;
    (!coreClkEn && !coreReset)[*3];
  endsequence
  // ==========
  // Bus handshake
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  // ==========
  // Reset, sleep and wake
  a_reset_hold: assert property (disable iff (1'b0) sys_rst |=> coreReset && !coreClkEn)
    else $error("reset does not hold core");
  a_clear_resets: assert property ($fell(masterClearPinN) |-> ##[1:4] coreReset)
    else $error("master clear ignored");
  a_in_floats: assert property (asleep3 |-> !oscInOe)
    else $error("oscillator input driven while asleep");
  a_out_low: assert property (asleep3 ##0 oscOutOe |-> !oscOutOut)
    else $error("oscillator output driven high while asleep");
  a_wake_branch: assert property (vectorReq |-> !resumeNext ##1 !vectorReq)
    else $error("vector and resume together");
  a_capture_awake: assert property (captureReq |-> coreClkEn)
    else $error("capture while asleep");
  c_sleep: cover property ($fell(coreClkEn));
  c_vector: cover property (vectorReq);
  c_resume: cover property (resumeNext);
endmodule // sleep_wake_sva

// ===== testbench/core_model.sv
// Processor core model issuing register accesses over classic Wishbone
`timescale 1ns/1ps
module core_model (
  // Clock
  input wire logic clock,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // ==========
  // One classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    @(posedge clock);
    while (wb_ack_i !== 1'b1) @(posedge clock);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Stale data would hide a slave that latches late
    wb_dat_o <= ~d;
  endtask
endmodule // core_model

// ===== testbench/test_sleep_wake_watchdog_control.sv
// Self-checking testbench for the sleep, wake-up and watchdog control block
`timescale 1ns/1ps
`include "sleep_wake_consts.vh"
module test_sleep_wake_watchdog_control;
  logic clock = 0;
  logic sys_rst = 1;
  logic masterClearPinN = 1;
  logic intPin = 0;
  logic sleepFetchIrq = 0;
  logic oscInPin = 0;
  logic [4:0] noise = 0;
  logic dogClk = 0;
  logic dogOn = 0;
  wire cyc, stb, we, ack, clkEn, vecReq, resNext;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdat, rdat;
  typedef struct {string s; logic [31:0] v; logic [31:0] m;} note_t;
  note_t notes[$];
  note_t n;
  logic [31:0] got;
  int fail_count = 0;
  int check_count = 0;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    noise <= 5'($urandom);
    oscInPin <= ~oscInPin;
    if (dogOn) dogClk <= ~dogClk;
  end
  core_model u_core (.clock(clock), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_ack_i(ack));
  sleep_wake_watchdog_control u_dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .masterClearPinN(masterClearPinN),
    .oscInPin(oscInPin), .dogRcClk(dogClk), .timerClockPin(noise[0]), .intPin(intPin),
    .captureOnePin(1'b0), .captureTwoEvt(noise[1]), .portBChange(noise[2]),
    .serialClkPin(noise[3]), .serialDataPin(noise[4]), .sleepFetchIrq(sleepFetchIrq),
    .timerEdgeSelect(1'b1), .timerExtClk(1'b1), .serialTxBusy(1'b0), .oscInOe(),
    .oscOutOut(), .oscOutOe(), .coreClkEn(clkEn), .coreReset(), .vectorReq(vecReq),
    .resumeNext(resNext), .timerPrescale(), .serialShift(), .captureReq());
  // ==========
  // Result watcher: every read answer or wake pulse consumes the oldest note
  always @(posedge clock) begin
    if ((ack && !we) || vecReq || resNext) begin
      got = (ack && !we) ? rdat : {30'h0, vecReq, resNext};
      check_count++;
      if (notes.size() == 0) begin
        fail_count++;
        $display("BAD unexpected result expected none seen %h", got);
      end else begin
        n = notes.pop_front();
        if (((got ^ n.v) & n.m) !== 32'h0) begin
          fail_count++;
          $display("BAD %s expected %h seen %h", n.s, n.v & n.m, got & n.m);
        end
      end
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_core.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input string s, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{s, v, m});
    u_core.xfer(1'b0, a, 32'h0);
  endtask
  task wait_clk(input logic lvl);
    int k;
    k = 0;
    while (clkEn !== lvl && k < 200) begin
      @(posedge clock);
      k++;
    end
    check_count++;
    if (clkEn !== lvl) begin
      fail_count++;
      $display("BAD coreClkEn expected %b seen %b", lvl, clkEn);
    end
  endtask
  // ==========
  // Sleep, poke the interrupt pin, and wake by interrupt or master clear
  task sleep_case(input logic [31:0] ctrl, input logic [31:0] wake);
    // Masks are latched at sleep entry, so they must already stand before it
    wr(`REG_CTRL_ADDR, ctrl & ~32'h1);
    wr(`REG_CTRL_ADDR, ctrl);
    wait_clk(1'b0);
    rd(`REG_STAT_ADDR, "status asleep", 32'ha, 32'he);
    if (wake != 0) notes.push_back('{"wake pulse", wake, 32'h3});
    @(posedge clock);
    intPin <= 1'b1;
    repeat (4) @(posedge clock);
    intPin <= 1'b0;
    repeat (10) @(posedge clock);
    if (wake != 0) begin
      wait_clk(1'b1);
    end else begin
      rd(`REG_STAT_ADDR, "status masked", 32'h2, 32'h2);
      masterClearPinN <= 1'b0;
      repeat (4) @(posedge clock);
      masterClearPinN <= 1'b1;
      wait_clk(1'b1);
      rd(`REG_CAUSE_ADDR, "wake cause", 32'h1, 32'h7);
    end
    repeat (20) @(posedge clock);
    rd(`REG_STAT_ADDR, "status woken", 32'h8, 32'he);
  endtask
  task complete_run;
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(48861));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(`REG_STAT_ADDR, "status at reset", 32'hffc, 32'hffe);
    wr(`REG_CTRL_ADDR, 32'h2);
    rd(`REG_STAT_ADDR, "status after kick", 32'h8, 32'h8);
    sleepFetchIrq <= 1'b1;
    wr(`REG_CTRL_ADDR, 32'h1);
    repeat (4) @(posedge clock);
    rd(`REG_STAT_ADDR, "status nop sleep", 32'h4, 32'h6);
    sleepFetchIrq <= 1'b0;
    sleep_case(32'h201, 32'h2);
    sleep_case(32'h205, 32'h1);
    sleep_case(32'h001, 32'h0);
    // Prescale 1 on erased fuses: 256 dog clock edges reach overflow
    dogOn <= 1'b1;
    repeat (600) @(posedge clock);
    dogOn <= 1'b0;
    rd(`REG_CAUSE_ADDR, "dog cause", 32'h2, 32'h7);
    rd(`REG_STAT_ADDR, "dog timeout", 32'h0, 32'h8);
    for (int i = 0; i < 2; i++) begin
      wr(`REG_TABLE_ADDR, (i == 0) ? 32'hfe02 : 32'hfe04);
      wr(`REG_TDATA_ADDR, $urandom);
      wr(`REG_CTRL_ADDR, 32'h20);
    end
    rd(`REG_STAT_ADDR, "fuse bits", 32'heb0, 32'hff0);
    wr(`REG_TABLE_ADDR, 32'hfe05);
    wr(`REG_CTRL_ADDR, 32'h10);
    repeat (4) @(posedge clock);
    rd(`REG_TDATA_ADDR, "fuse read", 32'hffeb, 32'hffff);
    rd(8'h40, "unmapped read", 32'h0, 32'hffffffff);
    repeat (20) @(posedge clock);
    complete_run();
  end
endmodule // test_sleep_wake_watchdog_control
bind sleep_wake_watchdog_control sleep_wake_sva u_sva (.clock(clock), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .masterClearPinN(masterClearPinN),
  .oscInOe(oscInOe), .oscOutOut(oscOutOut), .oscOutOe(oscOutOe), .coreClkEn(coreClkEn),
  .coreReset(coreReset), .vectorReq(vectorReq), .resumeNext(resumeNext),
  .captureReq(captureReq));
